// ---- hw/dcl_pkg.sv ----
/*
  Shared constants and types for the converter control block.
  Assumes a single synchronous clock and a word-wide register port.
*/
package dcl_pkg;

  // Instance bases in the internal address space
  localparam logic [31:0] DCL_BASE_INST0 = 32'h0000_8000;
  localparam logic [31:0] DCL_BASE_INST1 = 32'h0000_8040;

  // Register offsets
  localparam logic [31:0] DCL_OFS_ACT  = 32'h0000_0000;
  localparam logic [31:0] DCL_OFS_CFG  = 32'h0000_0004;
  localparam logic [31:0] DCL_OFS_CTRL = 32'h0000_0008;
  localparam logic [31:0] DCL_OFS_DATA = 32'h0000_000c;

  // Field positions and widths
  localparam int DCL_ACT_BIT  = 0;
  localparam int DCL_ON_BIT   = 0;
  localparam int DCL_SRST_BIT = 1;
  localparam int DCL_CFG_W    = 3;
  localparam int DCL_CODE_W   = 12;

  // Values after reset
  localparam logic                  DCL_ACT_RST  = 1'h0;
  localparam logic                  DCL_ON_RST   = 1'h0;
  localparam logic [DCL_CFG_W-1:0]  DCL_CFG_RST  = 3'h0;
  localparam logic [DCL_CODE_W-1:0] DCL_CODE_RST = 12'h000;

  // Timing: settle time of one conversion at 1 Msample/s
  localparam int DCL_CLK_PERIOD_NS = 50;
  localparam int DCL_CONV_TIME_NS  = 1000;
  localparam int DCL_CONV_CYCLES   =
    (DCL_CONV_TIME_NS + DCL_CLK_PERIOD_NS - 1) / DCL_CLK_PERIOD_NS;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcl_bus_req_t;

  typedef struct packed {
    logic sleep_ctl;
    logic pin_en;
    logic intrl_en;
  } dcl_cfg_t;

  typedef enum {
    DCL_DEACT,
    DCL_SLEEP,
    DCL_OFF,
    DCL_ON,
    DCL_CONV
  } dcl_pwr_t;

  function automatic logic dcl_hit(input logic [31:0] addr,
                                   input logic [31:0] base,
                                   input logic [31:0] ofs);
    dcl_hit = (addr == (base + ofs));
  endfunction : dcl_hit

endpackage : dcl_pkg

// ---- hw/dcl_soft_reset.sv ----
/*
  Self-clearing soft reset request and the combined converter reset.
  Assumes the request strobe is a one-cycle register write decode.
*/
`timescale 1ns/1ns
module dcl_soft_reset
(
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // Request
  input  wire logic srst_wr_in,
  // Converter reset
  output logic      conv_rst_out
);
  import dcl_pkg::*;

  logic pulse_ff;
  logic nxt_pulse;

  // Bit clears itself one cycle after a write of 1
  always_comb
  begin
    nxt_pulse = srst_wr_in;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      pulse_ff <= 1'h0;
    else
      pulse_ff <= nxt_pulse;
  end

  assign conv_rst_out = rst_in | pulse_ff;

  srst_self_clear_a : assert property (
    @(posedge clock_in) disable iff (rst_in)
      (pulse_ff && !srst_wr_in) |=> !pulse_ff)
    else $error("soft reset request did not clear itself");

endmodule : dcl_soft_reset

// ---- hw/dcl_power_fsm.sv ----
/*
  Power state sequencer: deactivated, sleeping, off, on and converting.
  Assumes kick is a one-cycle pulse on any change of on bit or code.
*/
`timescale 1ns/1ns
module dcl_power_fsm #(
  parameter int CONV_CYCLES = dcl_pkg::DCL_CONV_CYCLES
)
(
  // Clock and reset
  input  wire logic      clock_in,
  input  wire logic      conv_rst_in,
  // Conditions
  input  wire logic      active_in,
  input  wire logic      sleep_in,
  input  wire logic      on_in,
  input  wire logic      kick_in,
  // State
  output dcl_pkg::dcl_pwr_t state_out
);
  import dcl_pkg::*;

  dcl_pwr_t   state_ff;
  dcl_pwr_t   nxt_state;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (!active_in)
      nxt_state = DCL_DEACT;
    else if (sleep_in)
      nxt_state = DCL_SLEEP;
    else
    begin
      unique case (state_ff)
        DCL_DEACT, DCL_SLEEP, DCL_OFF, DCL_ON:
        begin
          nxt_cnt = 8'h00;
          if (kick_in)
            nxt_state = DCL_CONV;
          else
            nxt_state = on_in ? DCL_ON : DCL_OFF;
        end
        DCL_CONV:
        begin
          // A new change restarts the settle time
          if (kick_in)
            nxt_cnt = 8'h00;
          else if (cnt_ff == 8'(CONV_CYCLES - 1))
            nxt_state = on_in ? DCL_ON : DCL_OFF;
          else
            nxt_cnt = cnt_ff + 8'h01;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (conv_rst_in)
    begin
      state_ff <= DCL_DEACT;
      cnt_ff   <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign state_out = state_ff;

  conv_entry_a : assert property (
    @(posedge clock_in) disable iff (conv_rst_in)
      (kick_in && active_in && !sleep_in) |=> (state_ff == DCL_CONV))
    else $error("change of on bit or code did not start a conversion");

  conv_bound_a : assert property (
    @(posedge clock_in) disable iff (conv_rst_in)
      (state_ff == DCL_CONV) |-> (cnt_ff < 8'(CONV_CYCLES)))
    else $error("conversion ran past its settle time");

endmodule : dcl_power_fsm

// ---- hw/dcl_top.sv ----
/*
  Control logic of a 12-bit voltage output converter: register bank,
  power sequencing and output routing to pin and internal buffers.
  Assumes the embedded controller drives a single-cycle word port with
  full 32-bit addresses, and that analog parts follow the enables.
*/
// Overview of operation
// - System reset clears every register and state
// - Converter reset clears all but activation
// - Block runs from its single block clock
// - Inactive: analog off, clocks gated, registers usable
// - Obeyed sleep request turns analog off, gates clocks
// - Change of on bit or code starts conversion
// - Code is unsigned, full scale 4095
// - Registers sit at per-instance base address
// - Activate resets to zero; zero refuses enabling
// - Configuration writable only while converter off
// - Bit 2: obey sleep and tristate output
// - Bit 1: pin output buffer enable
// - Bit 0: internal output buffer enable
// - Soft reset bit self-clears; writing 0 ignored
// - On bit presents code via enabled buffers
`timescale 1ns/1ns
module dcl_top #(
  parameter logic [31:0] BASE_ADDR   = dcl_pkg::DCL_BASE_INST0,
  parameter int          CONV_CYCLES = dcl_pkg::DCL_CONV_CYCLES
)
(
  // Clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 rst_in,
  // Register port
  input  dcl_pkg::dcl_bus_req_t     bus_req_in,
  output logic [31:0]               rdata_out,
  output logic                      rvalid_out,
  // Chip sleep request
  input  wire logic                 sleep_req_in,
  // Analog core controls
  output logic                      analog_on_out,
  output logic                      clock_run_out,
  output logic                      pin_buffer_en_out,
  output logic                      internal_buffer_enable_out,
  output logic                      output_tristate_out,
  output logic                      converting_out,
  output logic [dcl_pkg::DCL_CODE_W-1:0] code_out
);
  import dcl_pkg::*;

  // Register bank state
  logic                  act_ff;
  logic                  nxt_act;
  dcl_cfg_t              cfg_ff;
  dcl_cfg_t              nxt_cfg;
  logic                  converter_running_flag_ff;
  logic                  nxt_on;
  logic [DCL_CODE_W-1:0] data_ff;
  logic [DCL_CODE_W-1:0] nxt_data;
  logic [31:0]           rdata_ff;
  logic [31:0]           nxt_rdata;
  logic                  rvalid_ff;
  logic                  nxt_rvalid;

  // Decode
  logic wr_act;
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_data;
  logic srst_wr;
  logic conv_rst;
  logic kick;
  logic sleep_eff;
  dcl_pwr_t state;

  // Output state
  logic                  analog_on_ff;
  logic                  nxt_analog_on;
  logic                  clock_run_ff;
  logic                  nxt_clock_run;
  logic                  pin_en_ff;
  logic                  nxt_pin_en;
  logic                  intrl_en_ff;
  logic                  nxt_intrl_en;
  logic                  tristate_ff;
  logic                  nxt_tristate;
  logic                  conv_ff;
  logic                  nxt_conv;
  logic [DCL_CODE_W-1:0] code_ff;
  logic [DCL_CODE_W-1:0] nxt_code;

  // Reserved slots and foreign addresses neither hit nor answer with data
  assign wr_act  = bus_req_in.wr && dcl_hit(bus_req_in.addr, BASE_ADDR, DCL_OFS_ACT);
  assign wr_cfg  = bus_req_in.wr && dcl_hit(bus_req_in.addr, BASE_ADDR, DCL_OFS_CFG);
  assign wr_ctrl = bus_req_in.wr && dcl_hit(bus_req_in.addr, BASE_ADDR, DCL_OFS_CTRL);
  assign wr_data = bus_req_in.wr && dcl_hit(bus_req_in.addr, BASE_ADDR, DCL_OFS_DATA);
  assign srst_wr = wr_ctrl && bus_req_in.wdata[DCL_SRST_BIT];

  dcl_soft_reset u_soft_reset (
    .clock_in     (clock_in),
    .rst_in       (rst_in),
    .srst_wr_in   (srst_wr),
    .conv_rst_out (conv_rst)
  );

  // Register writes
  always_comb
  begin
    nxt_act  = act_ff;
    nxt_cfg  = cfg_ff;
    nxt_on   = converter_running_flag_ff;
    nxt_data = data_ff;
    if (wr_act)
      nxt_act = bus_req_in.wdata[DCL_ACT_BIT];
    // Locked while running so the analog routing never changes under load
    if (wr_cfg && !converter_running_flag_ff)
      nxt_cfg = dcl_cfg_t'(bus_req_in.wdata[DCL_CFG_W-1:0]);
    if (wr_ctrl)
    begin
      if (!bus_req_in.wdata[DCL_ON_BIT])
        nxt_on = 1'h0;
      else if (act_ff)
        nxt_on = 1'h1;
    end
    if (wr_data)
      nxt_data = bus_req_in.wdata[DCL_CODE_W-1:0];
  end

  // Register reads; write-only and reserved bits read as zero
  always_comb
  begin
    nxt_rdata  = 32'h0000_0000;
    nxt_rvalid = bus_req_in.rd;
    if (bus_req_in.rd)
    begin
      if (dcl_hit(bus_req_in.addr, BASE_ADDR, DCL_OFS_ACT))
        nxt_rdata[DCL_ACT_BIT] = act_ff;
      else if (dcl_hit(bus_req_in.addr, BASE_ADDR, DCL_OFS_CFG))
        nxt_rdata[DCL_CFG_W-1:0] = cfg_ff;
      else if (dcl_hit(bus_req_in.addr, BASE_ADDR, DCL_OFS_CTRL))
        nxt_rdata[DCL_ON_BIT] = converter_running_flag_ff;
      else if (dcl_hit(bus_req_in.addr, BASE_ADDR, DCL_OFS_DATA))
        nxt_rdata[DCL_CODE_W-1:0] = data_ff;
    end
  end

  // Activation survives the soft reset; only system reset or a write of 0 clears it
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      act_ff    <= DCL_ACT_RST;
      rdata_ff  <= 32'h0000_0000;
      rvalid_ff <= 1'h0;
    end
    else
    begin
      act_ff    <= nxt_act;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (conv_rst)
    begin
      cfg_ff                    <= dcl_cfg_t'(DCL_CFG_RST);
      converter_running_flag_ff <= DCL_ON_RST;
      data_ff                   <= DCL_CODE_RST;
    end
    else
    begin
      cfg_ff                    <= nxt_cfg;
      converter_running_flag_ff <= nxt_on;
      data_ff                   <= nxt_data;
    end
  end

  // Sleep counts only when the converter is configured to obey it
  assign sleep_eff = sleep_req_in && cfg_ff.sleep_ctl;
  assign kick      = (nxt_on != converter_running_flag_ff) || (nxt_data != data_ff);

  dcl_power_fsm #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_power_fsm (
    .clock_in    (clock_in),
    .conv_rst_in (conv_rst),
    .active_in   (act_ff),
    .sleep_in    (sleep_eff),
    .on_in       (converter_running_flag_ff),
    .kick_in     (kick),
    .state_out   (state)
  );

  // Analog controls follow the power state
  always_comb
  begin
    nxt_analog_on = ((state == DCL_ON) || (state == DCL_CONV)) && converter_running_flag_ff;
    nxt_clock_run = (state != DCL_DEACT) && (state != DCL_SLEEP);
    nxt_pin_en    = nxt_analog_on && cfg_ff.pin_en;
    nxt_intrl_en  = nxt_analog_on && cfg_ff.intrl_en;
    nxt_tristate  = (state == DCL_SLEEP);
    nxt_conv      = (state == DCL_CONV);
    // Unsigned code; the core scales it by reference over 4095
    nxt_code      = data_ff;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      analog_on_ff <= 1'h0;
      clock_run_ff <= 1'h0;
      pin_en_ff    <= 1'h0;
      intrl_en_ff  <= 1'h0;
      tristate_ff  <= 1'h0;
      conv_ff      <= 1'h0;
      code_ff      <= DCL_CODE_RST;
    end
    else
    begin
      analog_on_ff <= nxt_analog_on;
      clock_run_ff <= nxt_clock_run;
      pin_en_ff    <= nxt_pin_en;
      intrl_en_ff  <= nxt_intrl_en;
      tristate_ff  <= nxt_tristate;
      conv_ff      <= nxt_conv;
      code_ff      <= nxt_code;
    end
  end

  assign rdata_out                  = rdata_ff;
  assign rvalid_out                 = rvalid_ff;
  assign analog_on_out              = analog_on_ff;
  assign clock_run_out              = clock_run_ff;
  assign pin_buffer_en_out          = pin_en_ff;
  assign internal_buffer_enable_out = intrl_en_ff;
  assign output_tristate_out        = tristate_ff;
  assign converting_out             = conv_ff;
  assign code_out                   = code_ff;

  sys_reset_a : assert property (
    @(posedge clock_in)
      rst_in |=> (!act_ff && !converter_running_flag_ff && data_ff == DCL_CODE_RST))
    else $error("system reset left state behind");

  soft_reset_a : assert property (
    @(posedge clock_in) disable iff (rst_in)
      (srst_wr && !wr_act) ##1 !wr_act |=>
        (!converter_running_flag_ff && data_ff == DCL_CODE_RST
         && act_ff == $past(act_ff, 2)))
    else $error("soft reset did not clear the converter registers");

  refuse_on_a : assert property (
    @(posedge clock_in) disable iff (rst_in)
      $rose(converter_running_flag_ff) |-> $past(act_ff))
    else $error("converter enabled while inactive");

  cfg_lock_a : assert property (
    @(posedge clock_in) disable iff (conv_rst)
      (wr_cfg && converter_running_flag_ff) |=> $stable(cfg_ff))
    else $error("configuration changed while running");

  deact_gate_a : assert property (
    @(posedge clock_in) disable iff (conv_rst)
      (!act_ff ##1 !act_ff) |=> (!clock_run_out && !analog_on_out))
    else $error("inactive block kept clocks or analog running");

  sleep_tri_a : assert property (
    @(posedge clock_in) disable iff (conv_rst)
      output_tristate_out |-> $past(sleep_eff, 2))
    else $error("output tristated without an obeyed sleep");

  pin_route_a : assert property (
    @(posedge clock_in) disable iff (rst_in)
      pin_buffer_en_out |-> ($past(cfg_ff.pin_en) && $past(converter_running_flag_ff)))
    else $error("pin buffer enabled without its enable or on bit");

  intrl_route_a : assert property (
    @(posedge clock_in) disable iff (rst_in)
      internal_buffer_enable_out |-> ($past(cfg_ff.intrl_en) && analog_on_out))
    else $error("internal buffer enabled without its enable");

  code_read_a : assert property (
    @(posedge clock_in) disable iff (rst_in)
      (bus_req_in.rd && !bus_req_in.wr
       && dcl_hit(bus_req_in.addr, BASE_ADDR, DCL_OFS_DATA))
        |=> (rvalid_out && rdata_out == {20'h00000, $past(data_ff)}))
    else $error("code register read back wrong");

  cfg_read_a : assert property (
    @(posedge clock_in) disable iff (rst_in)
      (bus_req_in.rd && dcl_hit(bus_req_in.addr, BASE_ADDR, DCL_OFS_CFG))
        |=> (rvalid_out && rdata_out == {29'h0, $past(cfg_ff)}))
    else $error("configuration read back wrong");

  sleep_off_a : assert property (
    @(posedge clock_in) disable iff (rst_in)
      output_tristate_out |-> (!analog_on_out && !clock_run_out))
    else $error("sleeping block kept clocks or analog running");

endmodule : dcl_top

// ---- bench/dcl_analog_model.sv ----
/*
  Behavioural analog core behind the converter control block: ladder,
  pin buffer and internal buffer feeding the comparator.
  Assumes the control outputs are registered levels on one clock.
*/
`timescale 1ns/1ns
module dcl_analog_model #(
  parameter int VREF_MV = 3300
)
(
  // Controls from the block
  input  wire logic        clock_in,
  input  wire logic        analog_on_in,
  input  wire logic        pin_en_in,
  input  wire logic        intrl_en_in,
  input  wire logic        tristate_in,
  input  wire logic [11:0] code_in,
  // Analog results in millivolts
  output logic             pin_driven_out,
  output int               pin_mv_out,
  output int               int_mv_out
);
  int ladder_mv;
  int junk = 0;
  // Unsigned code over a 4095 full scale
  assign ladder_mv = VREF_MV * int'(code_in) / 4095;
  assign pin_driven_out = analog_on_in & pin_en_in & ~tristate_in;
  // An undriven output wanders so a stale level never passes for a match
  always @(posedge clock_in) junk <= junk + 977;
  assign pin_mv_out = pin_driven_out ? ladder_mv : junk;
  assign int_mv_out = (analog_on_in & intrl_en_in) ? ladder_mv : -junk;
endmodule : dcl_analog_model

// ---- bench/testbench.sv ----
/*
  Self-checking bench for the converter control block.
  Assumes the analog model beside it and one 50 ns clock.
*/
`timescale 1ns/1ns
module testbench;
  import dcl_pkg::*;
  localparam int          CONV = 6;
  localparam int          VREF = 3300;
  localparam logic [31:0] B    = DCL_BASE_INST0;
  logic                  clock_in  = 1'b0;
  logic                  rst_in    = 1'b1;
  dcl_bus_req_t          req       = '0;
  logic                  sleep_req = 1'b0;
  logic [31:0]           rdata;
  logic                  rvalid, an_on, clk_run, pin_en, int_en, tri_st, conv;
  logic [DCL_CODE_W-1:0] code;
  logic                  pin_drv;
  int                    pin_mv, int_mv;
  int                    bad_count   = 0;
  int                    check_count = 0;

  always #25 clock_in = ~clock_in;

  dcl_top #(.BASE_ADDR(B), .CONV_CYCLES(CONV)) u_dut (
    .clock_in(clock_in), .rst_in(rst_in), .bus_req_in(req), .rdata_out(rdata),
    .rvalid_out(rvalid), .sleep_req_in(sleep_req), .analog_on_out(an_on),
    .clock_run_out(clk_run), .pin_buffer_en_out(pin_en),
    .internal_buffer_enable_out(int_en), .output_tristate_out(tri_st),
    .converting_out(conv), .code_out(code));

  dcl_analog_model #(.VREF_MV(VREF)) u_core (
    .clock_in(clock_in), .analog_on_in(an_on), .pin_en_in(pin_en),
    .intrl_en_in(int_en), .tristate_in(tri_st), .code_in(code),
    .pin_driven_out(pin_drv), .pin_mv_out(pin_mv), .int_mv_out(int_mv));

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask : tick

  // Idle cycle after each strobe so no signal is set twice in one step
  task automatic wr(input logic [31:0] ofs, input logic [31:0] d);
    req.wr = 1'b1;
    req.addr = B + ofs;
    req.wdata = d;
    tick(1);
    req.wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rc(input logic [31:0] addr, input logic [31:0] exp);
    int n;
    n = 0;
    req.rd = 1'b1;
    req.addr = addr;
    tick(1);
    req.rd = 1'b0;
    while (rvalid !== 1'b1 && n < 3)
    begin
      tick(1);
      n++;
    end
    check({31'h0, rvalid}, 32'h1);
    check(rdata, exp);
    tick(1);
  endtask : rc

  function automatic logic [4:0] exp_out(input logic [2:0] cfg, input logic on,
                                         input logic act, input logic slp);
    logic asleep, run, ana;
    asleep = act & slp & cfg[2];
    run = act & ~asleep;
    ana = run & on;
    return {asleep, run, ana, ana & cfg[1], ana & cfg[0]};
  endfunction : exp_out

  function automatic int exp_mv(input logic [31:0] c);
    return VREF * int'(c[11:0]) / 4095;
  endfunction : exp_mv

  task automatic chk_out(input logic [2:0] cfg, input logic on, input logic act,
                         input logic slp);
    check({27'h0, tri_st, clk_run, an_on, pin_en, int_en},
          {27'h0, exp_out(cfg, on, act, slp)});
  endtask : chk_out

  initial
  begin
    logic [31:0] c;
    void'($urandom(32'h4107));
    tick(4);
    rst_in = 1'b0;
    tick(1);
    for (int i = 0; i < 4; i++) rc(B + 4 * i, 32'h0);
    chk_out(3'h0, 1'b0, 1'b0, 1'b0);
    wr(DCL_OFS_CTRL, 32'h1);
    rc(B + DCL_OFS_CTRL, 32'h0);
    for (int o = 'h10; o <= 'h30; o += 4) rc(B + o, 32'h0);
    $display("test defaults done");
    wr(DCL_OFS_ACT, 32'hffff_ffff);
    rc(B, 32'h1);
    rc(DCL_BASE_INST1, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      c = (k == 7) ? 32'hffff_ffff : $urandom;
      wr(DCL_OFS_CTRL, 32'h0);
      wr(DCL_OFS_CFG, k | (c & 32'hffff_fff8));
      wr(DCL_OFS_DATA, c);
      rc(B + DCL_OFS_CFG, k);
      rc(B + DCL_OFS_DATA, c & 32'hfff);
      wr(DCL_OFS_CTRL, 32'h1);
      tick(2);
      check({31'h0, conv}, 32'h1);
      tick(CONV + 2);
      check({31'h0, conv}, 32'h0);
      chk_out(3'(k), 1'b1, 1'b1, 1'b0);
      check({20'h0, code}, c & 32'hfff);
      check({31'h0, pin_drv}, (k >> 1) & 1);
      if (k[1]) check(pin_mv, exp_mv(c));
      if (k[0]) check(int_mv, exp_mv(c));
      wr(DCL_OFS_CFG, ~k & 32'h7);
      rc(B + DCL_OFS_CFG, k);
      wr(DCL_OFS_DATA, c ^ ($urandom | 32'h1));
      tick(2);
      check({31'h0, conv}, 32'h1);
      tick(CONV + 2);
      sleep_req = 1'b1;
      tick(3);
      chk_out(3'(k), 1'b1, 1'b1, 1'b1);
      sleep_req = 1'b0;
      tick(3);
      chk_out(3'(k), 1'b1, 1'b1, 1'b0);
    end
    // Disabled before sleep, so waking must not bring the output back
    wr(DCL_OFS_CTRL, 32'h0);
    sleep_req = 1'b1;
    tick(CONV + 4);
    chk_out(3'h7, 1'b0, 1'b1, 1'b1);
    sleep_req = 1'b0;
    tick(3);
    chk_out(3'h7, 1'b0, 1'b1, 1'b0);
    check({31'h0, pin_drv}, 32'h0);
    $display("test configurations done");
    // Soft reset with the on bit also set: the reset must win
    wr(DCL_OFS_CTRL, 32'h3);
    tick(2);
    rc(B + DCL_OFS_CTRL, 32'h0);
    rc(B + DCL_OFS_CFG, 32'h0);
    rc(B + DCL_OFS_DATA, 32'h0);
    rc(B, 32'h1);
    wr(DCL_OFS_CTRL, 32'h1);
    tick(CONV + 4);
    chk_out(3'h0, 1'b1, 1'b1, 1'b0);
    wr(DCL_OFS_ACT, 32'h0);
    tick(3);
    chk_out(3'h0, 1'b1, 1'b0, 1'b0);
    $display("test soft reset done");
    wr(DCL_OFS_ACT, 32'h1);
    rst_in = 1'b1;
    tick(2);
    rst_in = 1'b0;
    tick(1);
    rc(B, 32'h0);
    rc(B + DCL_OFS_CTRL, 32'h0);
    chk_out(3'h0, 1'b0, 1'b0, 1'b0);
    $display("test system reset done");
    summarize();
  end

  // Roughly four times the expected run length
  initial
  begin
    #(2000 * 50);
    bad_count++;
    summarize();
  end
endmodule : testbench
